// >>> bio_len_check.sv
`timescale 1ns/1ps
module bio_len_check
(
   input  wire logic            ref_clk,
   input  wire logic            rst_n,
   input  wire logic [3:0]      recCode,
   input  wire bio_pkg::bio_blk_t blkReq,
   output logic                 typeErrAck,
   output logic                 lenOk
);
   import bio_pkg::*;

   logic [17:0] maxBytes;

   // max length = 2^(code+1) bytes
   assign maxBytes = 18'h00001 << (5'(recCode) + 5'h01);

   // registered verdict, one cycle after the request
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         typeErrAck <= 1'b0;
         lenOk      <= 1'b0;
      end
      else
      begin
         typeErrAck <= blkReq.valid && ({2'h0, blkReq.length} > maxBytes);
         lenOk      <= blkReq.valid && ({2'h0, blkReq.length} <= maxBytes);
      end
   end
endmodule

// >>> bio_options.sv
`timescale 1ns/1ps
// Notes on behaviour
// - reserved bits 26-24, 11-8, 5-3 read zero
// - block limit is two to code-plus-one bytes
// - hard reset loads 2048 code, soft keeps
// - oversized block write may get type error
// - generation bumps after rom change since reset
// - link speed field always reads 010
// - bits 23-16 hold writable clock accuracy
// - register shown as second bus info quadlet
module bio_options
(
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic              softReset,
   input  wire logic              busReset,
   input  wire logic              romChanged,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic [31:0]            hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire bio_pkg::bio_blk_t blkReq,
   output logic                   typeErrAck,
   output logic                   blkLenOk,
   output logic [31:0]            busInfoQuadlet
);
   import bio_pkg::*;

   bio_req_t    req_reg;
   logic [4:0]  cap_reg;
   logic [7:0]  acc_reg;
   logic [3:0]  rec_reg;
   logic [1:0]  gen_reg;
   logic        romDirty_reg;
   logic [31:0] optWord;
   logic [31:0] wrMerged;
   logic        wrOpt;
   logic        wrRomChg;
   logic [31:0] rdWord;
   logic        addrPhase;
   logic        rdOpt;
   logic        rdRomChg;
   logic        romMark;
   logic        genBump;

   // assemble the word; reserved bits are constant zero
   function automatic logic [31:0] packWord(input logic [4:0] c, input logic [7:0] a,
                                            input logic [3:0] r, input logic [1:0] g);
      packWord = {c, 3'h0, a, r, 4'h0, g, 3'h0, BIO_LINK_SPEED};
   endfunction

   // options decode, shared by the read and the write side
   function automatic logic isOptAddr(input logic [7:0] addr);
      isOptAddr = (addr == BIO_OPTIONS_OFFSET);
   endfunction

   // only the low byte is decoded, so both registers repeat every 256 bytes
   function automatic logic isRomChgAddr(input logic [7:0] addr);
      isRomChgAddr = (addr == BIO_ROMCHG_OFFSET);
   endfunction

   assign optWord        = packWord(cap_reg, acc_reg, rec_reg, gen_reg);
   assign busInfoQuadlet = optWord;
   assign hreadyout      = 1'b1;    // zero wait states
   assign hresp          = 1'b0;    // always okay

   // read address phase, decoded straight off the bus
   assign addrPhase = hready && hsel && (htrans == BIO_HTRANS_NONSEQ);
   assign rdOpt     = addrPhase && !hwrite && isOptAddr(haddr[7:0]);
   assign rdRomChg  = addrPhase && !hwrite && isRomChgAddr(haddr[7:0]);

   // data phase writes, qualified by the captured address phase
   assign wrOpt    = req_reg.valid && req_reg.write && isOptAddr(req_reg.addr);
   assign wrRomChg = req_reg.valid && req_reg.write && isRomChgAddr(req_reg.addr);
   assign wrMerged = (hwdata & BIO_WRITE_MASK) | (optWord & ~BIO_WRITE_MASK);

   // a change flagged or written this cycle already counts as pending
   assign romMark = romChanged || (wrRomChg && hwdata[0]);
   assign genBump = busReset && romDirty_reg;

   // read word; a write in its data phase is forwarded so back to back works
   always_comb
   begin
      rdWord = 32'h00000000; // unmapped reads zero
      if (rdOpt)
         rdWord = wrOpt ? wrMerged : optWord;
      else if (rdRomChg)
         rdWord = {31'h0, romDirty_reg || romMark};
   end

   // address phase capture; only whole-word writes act, reads answer at any size
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         req_reg <= '0;
      else if (hready)
      begin
         req_reg.valid <= hsel && (htrans == BIO_HTRANS_NONSEQ) && (hsize == BIO_HSIZE_WORD);
         req_reg.write <= hwrite;
         req_reg.addr  <= haddr[7:0];
      end
   end

   // read data registered in address phase so it stands in the data phase
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         hrdata <= 32'h00000000;
      else if (addrPhase && !hwrite)
         hrdata <= rdWord;
   end

   // capability flags; soft reset leaves them alone
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         cap_reg <= BIO_CAP_RESET;
      else if (wrOpt)
         cap_reg <= wrMerged[BIO_CAP_LSB +: 5];
   end

   // cycle master clock accuracy in ppm; soft reset leaves it alone
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         acc_reg <= BIO_ACC_RESET;
      else if (wrOpt)
         acc_reg <= wrMerged[BIO_ACC_LSB +: 8];
   end

   // block size code: hard reset only, soft reset is a no-op here
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         rec_reg <= BIO_REC_HARD_RESET;
      else if (wrOpt)
         rec_reg <= wrMerged[BIO_REC_LSB +: 4]; // software's duty to keep legal
   end

   // rom change seen since last bus reset; a new change beats the reset clear
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         romDirty_reg <= 1'b0;
      else if (romMark)
         romDirty_reg <= 1'b1;
      else if (busReset)
         romDirty_reg <= 1'b0;
   end

   // generation: bumped at bus reset if rom changed, else software write
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         gen_reg <= BIO_GEN_RESET;
      else if (genBump)
         gen_reg <= gen_reg + 2'h1;
      else if (wrOpt)
         gen_reg <= wrMerged[BIO_GEN_LSB +: 2];
   end

   // receive-side length check on the programmed code
   bio_len_check u_len
   (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .recCode    (rec_reg),
      .blkReq     (blkReq),
      .typeErrAck (typeErrAck),
      .lenOk      (blkLenOk)
   );

   // soft reset intentionally affects nothing in this register
   logic unusedSoft;
   assign unusedSoft = softReset;
endmodule

// >>> bio_options_monitor.sv
`timescale 1ns/1ps
module bio_options_monitor
(
   input wire logic              ref_clk,
   input wire logic              rst_n,
   input wire logic              softReset,
   input wire logic              hsel,
   input wire logic [31:0]       haddr,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic [2:0]        hsize,
   input wire logic [31:0]       hwdata,
   input wire logic              hresp,
   input wire bio_pkg::bio_blk_t blkReq,
   input wire logic              typeErrAck,
   input wire logic              blkLenOk,
   input wire logic [31:0]       busInfoQuadlet
);
   import bio_pkg::*;
   logic [16:0] lim;
   // limit in bytes, 17 bits so code 15 fits
   assign lim = 17'h1 << (busInfoQuadlet[15:12] + 5'h1);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_rsv; (busInfoQuadlet & 32'h07000f38) == 32'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bit set");
   property p_spd; busInfoQuadlet[2:0] == 3'h2; endproperty
   a_spd: assert property (p_spd) else $error("speed code wrong");
   property p_err; blkReq.valid && {1'b0, blkReq.length} > lim |=> typeErrAck && !blkLenOk;
   endproperty
   a_err: assert property (p_err) else $error("long block not flagged");
   property p_ok; blkReq.valid && {1'b0, blkReq.length} <= lim |=> blkLenOk && !typeErrAck;
   endproperty
   a_ok: assert property (p_ok) else $error("short block flagged");
   property p_idle; !blkReq.valid |=> !typeErrAck && !blkLenOk; endproperty
   a_idle: assert property (p_idle) else $error("stray length answer");
   property p_hrd; $rose(rst_n) |-> busInfoQuadlet == 32'h0000a002; endproperty
   a_hrd: assert property (p_hrd) else $error("hard reset value wrong");
   property p_soft; softReset && !hsel && !$past(hsel) |=> $stable(busInfoQuadlet[15:12]);
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset moved code");
   property p_wr; hsel && htrans == 2'h2 && hsize == 3'h2 && hwrite && haddr == 32'h20
      |=> ##1 (busInfoQuadlet & 32'hf8fff000) == ($past(hwdata) & 32'hf8fff000); endproperty
   a_wr: assert property (p_wr) else $error("write not shown");
   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("error response seen");
endmodule
bind bio_options bio_options_monitor i_mon
(
   .ref_clk        (ref_clk),
   .rst_n          (rst_n),
   .softReset      (softReset),
   .hsel           (hsel),
   .haddr          (haddr),
   .htrans         (htrans),
   .hwrite         (hwrite),
   .hsize          (hsize),
   .hwdata         (hwdata),
   .hresp          (hresp),
   .blkReq         (blkReq),
   .typeErrAck     (typeErrAck),
   .blkLenOk       (blkLenOk),
   .busInfoQuadlet (busInfoQuadlet)
);

// >>> bio_pkg.sv
package bio_pkg;

   // register map
   localparam logic [7:0]  BIO_OPTIONS_OFFSET  = 8'h20;
   localparam logic [7:0]  BIO_ROMCHG_OFFSET   = 8'h40;
   // field positions
   localparam int          BIO_CAP_LSB         = 27;
   localparam int          BIO_ACC_LSB         = 16;
   localparam int          BIO_REC_LSB         = 12;
   localparam int          BIO_GEN_LSB         = 6;
   // reset values
   localparam logic [3:0]  BIO_REC_HARD_RESET  = 4'ha; // 2^(10+1) = 2048 bytes
   localparam logic [4:0]  BIO_CAP_RESET       = 5'h00;
   localparam logic [7:0]  BIO_ACC_RESET       = 8'h00;
   localparam logic [1:0]  BIO_GEN_RESET       = 2'h0;
   localparam logic [2:0]  BIO_LINK_SPEED      = 3'h2; // 100/200/400 Mbit/s
   // writable bits of the options word
   localparam logic [31:0] BIO_WRITE_MASK      = 32'hf8fff0c0;
   localparam logic [1:0]  BIO_HTRANS_NONSEQ   = 2'h2;
   localparam logic [2:0]  BIO_HSIZE_WORD      = 3'h2;

   // ahb-lite request captured in the address phase
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
   } bio_req_t;

   // block request length check
   typedef struct packed {
      logic        valid;
      logic [15:0] length;
   } bio_blk_t;

endpackage

// >>> test_bio_options.sv
`timescale 1ns/1ps
module test_bio_options;
   import bio_pkg::*;
   logic        ref_clk = 0, rst_n = 0, softReset = 0, busReset = 0, romChanged = 0;
   logic        hsel = 0, hwrite = 0, rdPh = 0, hready, hreadyout, hresp, typeErrAck, blkLenOk;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = BIO_HSIZE_WORD;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, busInfoQuadlet, d;
   bio_blk_t    blkReq = '0;
   int          err_total = 0, n_compared = 0;
   logic [31:0] expQ[$];
   assign hready = hreadyout;
   bio_options i_dut
   (
      .ref_clk        (ref_clk),
      .rst_n          (rst_n),
      .softReset      (softReset),
      .busReset       (busReset),
      .romChanged     (romChanged),
      .hsel           (hsel),
      .haddr          (haddr),
      .htrans         (htrans),
      .hwrite         (hwrite),
      .hsize          (hsize),
      .hwdata         (hwdata),
      .hready         (hready),
      .hrdata         (hrdata),
      .hreadyout      (hreadyout),
      .hresp          (hresp),
      .blkReq         (blkReq),
      .typeErrAck     (typeErrAck),
      .blkLenOk       (blkLenOk),
      .busInfoQuadlet (busInfoQuadlet)
   );
   always #20 ref_clk = ~ref_clk;
   // oldest note against each result seen
   task automatic chk(logic [31:0] got);
      logic [31:0] e;
      e = expQ.size() ? expQ.pop_front() : 32'hdeadbeef;
      n_compared++;
      if (got !== e)
      begin
         err_total++;
         $display("mismatch %0t got %h exp %h", $time, got, e);
      end
   endtask
   always @(posedge ref_clk)
   begin
      if (rdPh) chk(hrdata);
      if ((typeErrAck | blkLenOk) !== 1'b0) chk({30'h0, typeErrAck, blkLenOk});
      rdPh <= hsel && htrans == BIO_HTRANS_NONSEQ && !hwrite;
   end
   // one ahb single transfer, waits on hready
   task automatic xfer(logic w, logic [31:0] a, logic [31:0] v);
      if (!w) expQ.push_back(v);
      hsel <= 1;
      htrans <= BIO_HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= a;
      do @(posedge ref_clk); while (!hready);
      hsel <= 0;
      htrans <= 0;
      hwdata <= v;
      do @(posedge ref_clk); while (!hready);
   endtask
   task automatic blk(logic [15:0] len, logic [31:0] e);
      expQ.push_back(e);
      blkReq <= '{1'b1, len};
      @(posedge ref_clk);
      blkReq.valid <= 0;
      @(posedge ref_clk);
   endtask
   task automatic bus_reset();
      busReset <= 1;
      @(posedge ref_clk);
      busReset <= 0;
      @(posedge ref_clk);
   endtask
   task automatic give_verdict();
      if (expQ.size() != 0)
      begin
         err_total++;
         $display("mismatch %0t %0d results never seen", $time, expQ.size());
      end
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // main sequence
   initial
   begin
      d = $urandom(32'h89b48560);
      repeat (5) @(posedge ref_clk);
      rst_n <= 1;
      @(posedge ref_clk);
      xfer(0, 32'h20, 32'h0000a002);
      $display("hard reset value test done");
      repeat (4)
      begin
         d = $urandom | 32'h00008000; // code of 8 or more keeps 512 bytes
         xfer(1, 32'h20, d);
         xfer(0, 32'h20, d & BIO_WRITE_MASK | 32'h2);
      end
      hsize <= 3'h0;
      xfer(1, 32'h20, 32'h0);
      hsize <= BIO_HSIZE_WORD;
      xfer(0, 32'h20, d & BIO_WRITE_MASK | 32'h2);
      xfer(0, 32'h24, 32'h0);
      $display("write and read back test done");
      for (int c = 8; c < 15; c++)
      begin
         xfer(1, 32'h20, c << 12);
         blk(16'(1 << (c + 1)), 32'h1);
         blk(16'(1 << (c + 1)) + 16'h1, 32'h2);
      end
      $display("block length test done");
      softReset <= 1;
      repeat (3) @(posedge ref_clk);
      softReset <= 0;
      xfer(0, 32'h20, 32'h0000e002);
      $display("soft reset test done");
      romChanged <= 1;
      @(posedge ref_clk);
      romChanged <= 0;
      xfer(0, {24'h0, BIO_ROMCHG_OFFSET}, 32'h1);
      bus_reset();
      bus_reset();
      xfer(0, 32'h20, 32'h0000e042);
      xfer(0, {24'h0, BIO_ROMCHG_OFFSET}, 32'h0);
      xfer(1, {24'h0, BIO_ROMCHG_OFFSET}, 32'h1);
      bus_reset();
      xfer(0, 32'h20, 32'h0000e082);
      $display("generation test done");
      rst_n <= 0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1;
      @(posedge ref_clk);
      xfer(0, 32'h20, 32'h0000a002);
      repeat (3) @(posedge ref_clk);
      $display("mid-run reset test done");
      give_verdict();
   end
   initial
   begin
      #100000;
      err_total++;
      give_verdict();
   end
endmodule
